// >>> design/bds_pkg.sv
// shared constants and carrier types of the bridge driver status registers
package bds_pkg;

  // ----------------------------------------------------------------
  // register addresses on the 7-bit serial register address space
  // ----------------------------------------------------------------
  localparam int          BDS_ADDR_W    = 7;
  localparam int          BDS_DATA_W    = 16;
  localparam logic [6:0]  BDS_ADDR_GEN  = 7'h50;   // bridge_general_status
  localparam logic [6:0]  BDS_ADDR_REG  = 7'h51;   // gate_delay_regulation_status

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BDS_GEN_B2_LEVEL   = 7;
  localparam int BDS_GEN_B1_LEVEL   = 6;
  localparam int BDS_GEN_PWM_PIN    = 0;
  localparam int BDS_REG_B2_PREDIS  = 9;
  localparam int BDS_REG_B1_PREDIS  = 8;
  localparam int BDS_REG_B2_PRE     = 5;
  localparam int BDS_REG_B1_PRE     = 4;
  localparam int BDS_REG_B2_DELAY   = 1;
  localparam int BDS_REG_B1_DELAY   = 0;

  // ----------------------------------------------------------------
  // reset values and restart keep mask
  // ----------------------------------------------------------------
  localparam logic [15:0] BDS_GEN_RESET = 16'h0000;
  localparam logic [15:0] BDS_REG_RESET = 16'h0000;
  localparam logic [15:0] BDS_KEEP_MASK = 16'h00C1;  // bits 7, 6, 0 stay live on restart
  localparam logic [15:0] BDS_GEN_USED  = 16'h00C1;
  localparam logic [15:0] BDS_REG_USED  = 16'h0333;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BDS_MODE_ACTIVE = 2'b11;   // bridge driven, level sense valid
  localparam logic [1:0] BDS_GCTL_ON_LO  = 2'b10;
  localparam logic [1:0] BDS_GCTL_ON_HI  = 2'b11;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // per-bridge configuration, same clock domain
  typedef struct packed {
    logic [1:0] mode;
    logic       pwm_on;
    logic       high_z;
  } bds_bridge_cfg_s;

  // per-bridge analogue sense results, asynchronous to clk
  typedef struct packed {
    logic out_high;       // supply minus source at or below threshold
    logic pre_clamp;      // precharge current at min or max clamp
    logic predis_clamp;   // predischarge current at min or max clamp
    logic delay_reg;      // turn-on and/or turn-off delay in regulation
  } bds_bridge_sense_s;

  // per-bridge qualified status bits
  typedef struct packed {
    logic level;
    logic pre_st;
    logic predis_st;
    logic delay_st;
  } bds_bridge_stat_s;

  // register access request
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [BDS_ADDR_W-1:0] addr;
    logic [BDS_DATA_W-1:0] wdata;
  } bds_acc_s;

endpackage : bds_pkg

// >>> design/bds_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module bds_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ----------------------------------------------------------------
  // shift chain; stage1 feeds only stage2
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept per bit only when the two settled stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      sync_out <= (stage2 & stage3) | (sync_out & (stage2 | stage3));
    end
  end

endmodule : bds_sync3

// >>> design/bds_bridge_qual.sv
// per-bridge qualification of synchronised sense results into status bits
`timescale 1ns/1ps
module bds_bridge_qual
  import bds_pkg::*;
(
  input  wire bds_pkg::bds_bridge_cfg_s   cfg,
  input  wire bds_pkg::bds_bridge_sense_s sense,
  input  wire logic                       charge_pump_on,
  input  wire logic [1:0]                 adaptive_gate_control,
  output bds_pkg::bds_bridge_stat_s       stat
);

  logic level_valid;
  logic clamp_active;

  // ----------------------------------------------------------------
  // qualification
  // ----------------------------------------------------------------
  // level is only meaningful with the pump running and the bridge driven
  assign level_valid  = charge_pump_on && (cfg.mode == BDS_MODE_ACTIVE);
  // clamp report needs adaptive control on, pwm on and a driven bridge
  assign clamp_active = cfg.pwm_on && !cfg.high_z &&
                        ((adaptive_gate_control == BDS_GCTL_ON_LO) ||
                         (adaptive_gate_control == BDS_GCTL_ON_HI));

  // status bits: level gated to 0, clamp bits default to 1 when inactive
  always_comb begin
    stat.level     = level_valid && sense.out_high;
    stat.pre_st    = !(clamp_active && sense.pre_clamp);
    stat.predis_st = !(clamp_active && sense.predis_clamp);
    stat.delay_st  = sense.delay_reg;
  end

endmodule : bds_bridge_qual

// >>> design/bds_status_regs.sv
// bridge driver status registers: output level, pwm pin, gate current clamps, delay regulation
`timescale 1ns/1ps
module bds_status_regs
  import bds_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       restart,
  input  wire logic                       pwm_pin_level,
  input  wire bds_pkg::bds_bridge_sense_s bridge1_sense,
  input  wire bds_pkg::bds_bridge_sense_s bridge2_sense,
  input  wire bds_pkg::bds_bridge_cfg_s   bridge1_cfg,
  input  wire bds_pkg::bds_bridge_cfg_s   bridge2_cfg,
  input  wire logic                       charge_pump_on,
  input  wire logic [1:0]                 adaptive_gate_control,
  input  wire bds_pkg::bds_acc_s          acc,
  output logic [bds_pkg::BDS_DATA_W-1:0]  acc_rdata,
  output logic                            acc_rvalid,
  output logic                            acc_miss
);

  import bds_pkg::*;

  localparam int SYNC_W = 1 + 2 * $bits(bds_bridge_sense_s);

  logic [SYNC_W-1:0]       raw_async;
  logic [SYNC_W-1:0]       raw_sync;
  logic                    pwm_sync;
  bds_bridge_sense_s       b1_sense_sync;
  bds_bridge_sense_s       b2_sense_sync;
  bds_bridge_stat_s        b1_stat;
  bds_bridge_stat_s        b2_stat;
  logic [BDS_DATA_W-1:0]   next_gen;
  logic [BDS_DATA_W-1:0]   next_reg;
  logic [BDS_DATA_W-1:0]   bridge_general_status;
  logic [BDS_DATA_W-1:0]   gate_delay_regulation_status;
  logic                    hit_gen;
  logic                    hit_reg;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  // pin and analogue comparator results all come from outside clk
  assign raw_async = {pwm_pin_level, bridge2_sense, bridge1_sense};

  bds_sync3 #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw_async),
    .sync_out (raw_sync)
  );

  assign pwm_sync      = raw_sync[SYNC_W-1];
  assign b2_sense_sync = raw_sync[2*$bits(bds_bridge_sense_s)-1:$bits(bds_bridge_sense_s)];
  assign b1_sense_sync = raw_sync[$bits(bds_bridge_sense_s)-1:0];

  // ----------------------------------------------------------------
  // per-bridge qualification
  // ----------------------------------------------------------------
  bds_bridge_qual u_qual1 (
    .cfg                   (bridge1_cfg),
    .sense                 (b1_sense_sync),
    .charge_pump_on        (charge_pump_on),
    .adaptive_gate_control (adaptive_gate_control),
    .stat                  (b1_stat)
  );

  bds_bridge_qual u_qual2 (
    .cfg                   (bridge2_cfg),
    .sense                 (b2_sense_sync),
    .charge_pump_on        (charge_pump_on),
    .adaptive_gate_control (adaptive_gate_control),
    .stat                  (b2_stat)
  );

  // ----------------------------------------------------------------
  // live register images
  // ----------------------------------------------------------------
  // every unused position is forced low here, so reserved bits cannot leak
  always_comb begin
    next_gen = '0;
    next_gen[BDS_GEN_B2_LEVEL]  = b2_stat.level;
    next_gen[BDS_GEN_B1_LEVEL]  = b1_stat.level;
    next_gen[BDS_GEN_PWM_PIN]   = pwm_sync;
    next_reg = '0;
    next_reg[BDS_REG_B2_PREDIS] = b2_stat.predis_st;
    next_reg[BDS_REG_B1_PREDIS] = b1_stat.predis_st;
    next_reg[BDS_REG_B2_PRE]    = b2_stat.pre_st;
    next_reg[BDS_REG_B1_PRE]    = b1_stat.pre_st;
    next_reg[BDS_REG_B2_DELAY]  = b2_stat.delay_st;
    next_reg[BDS_REG_B1_DELAY]  = b1_stat.delay_st;
  end

  // ----------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------
  // restart keeps the live bits and clears the rest for one cycle;
  // afterwards the registers track status again. writes never land here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bridge_general_status        <= BDS_GEN_RESET;
      gate_delay_regulation_status <= BDS_REG_RESET;
    end else if (restart) begin
      bridge_general_status        <= next_gen & BDS_KEEP_MASK;
      gate_delay_regulation_status <= next_reg & BDS_KEEP_MASK;
    end else begin
      bridge_general_status        <= next_gen;
      gate_delay_regulation_status <= next_reg;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  assign hit_gen = (acc.addr == BDS_ADDR_GEN);
  assign hit_reg = (acc.addr == BDS_ADDR_REG);

  // read returns the image, write is acknowledged but discarded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_rdata  <= '0;
      acc_rvalid <= 1'b0;
      acc_miss   <= 1'b0;
    end else begin
      acc_rvalid <= acc.rd || acc.wr;
      acc_miss   <= (acc.rd || acc.wr) && !hit_gen && !hit_reg;
      if (acc.rd && hit_gen) begin
        acc_rdata <= bridge_general_status;
      end else if (acc.rd && hit_reg) begin
        acc_rdata <= gate_delay_regulation_status;
      end else begin
        acc_rdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    ((bridge_general_status & ~BDS_GEN_USED) == '0) &&
    ((gate_delay_regulation_status & ~BDS_REG_USED) == '0))
    else $error("reserved status bit set");

  chk_level_gate: assert property (@(posedge clk) disable iff (rst)
    (!charge_pump_on || bridge2_cfg.mode != BDS_MODE_ACTIVE) |=> !bridge_general_status[BDS_GEN_B2_LEVEL])
    else $error("bridge-2 level set while gated");

  chk_level_b1: assert property (@(posedge clk) disable iff (rst)
    (charge_pump_on && bridge1_cfg.mode == BDS_MODE_ACTIVE && !restart)
      |=> bridge_general_status[BDS_GEN_B1_LEVEL] == $past(b1_sense_sync.out_high))
    else $error("bridge-1 level not reported");

  chk_level_b2: assert property (@(posedge clk) disable iff (rst)
    (charge_pump_on && bridge2_cfg.mode == BDS_MODE_ACTIVE)
      |=> bridge_general_status[BDS_GEN_B2_LEVEL] == $past(b2_sense_sync.out_high))
    else $error("bridge-2 level not reported");

  chk_pwm_mirror: assert property (@(posedge clk) disable iff (rst)
    $rose(pwm_sync) |=> bridge_general_status[BDS_GEN_PWM_PIN])
    else $error("pwm pin level not mirrored");

  chk_clamp_idle: assert property (@(posedge clk) disable iff (rst)
    (!restart && (!bridge1_cfg.pwm_on || bridge1_cfg.high_z || !adaptive_gate_control[1]))
      |=> gate_delay_regulation_status[BDS_REG_B1_PRE] && gate_delay_regulation_status[BDS_REG_B1_PREDIS])
    else $error("bridge-1 clamp bits low while inactive");

  chk_clamp_b2: assert property (@(posedge clk) disable iff (rst)
    (!restart && bridge2_cfg.pwm_on && !bridge2_cfg.high_z && adaptive_gate_control[1]
      && b2_sense_sync.pre_clamp && b2_sense_sync.predis_clamp)
      |=> !gate_delay_regulation_status[BDS_REG_B2_PRE] && !gate_delay_regulation_status[BDS_REG_B2_PREDIS])
    else $error("bridge-2 clamp not reported");

  chk_clamp_b1: assert property (@(posedge clk) disable iff (rst)
    (!restart && bridge1_cfg.pwm_on && !bridge1_cfg.high_z && adaptive_gate_control[1]
      && b1_sense_sync.pre_clamp && !b1_sense_sync.predis_clamp)
      |=> !gate_delay_regulation_status[BDS_REG_B1_PRE] && gate_delay_regulation_status[BDS_REG_B1_PREDIS])
    else $error("bridge-1 clamp bits wrong");

  chk_delay_bits: assert property (@(posedge clk) disable iff (rst)
    !restart |=> gate_delay_regulation_status[BDS_REG_B2_DELAY] == $past(b2_sense_sync.delay_reg) &&
                 gate_delay_regulation_status[BDS_REG_B1_DELAY] == $past(b1_sense_sync.delay_reg))
    else $error("delay regulation bits wrong");

  chk_restart_clear: assert property (@(posedge clk) disable iff (rst)
    restart |=> (gate_delay_regulation_status & ~BDS_KEEP_MASK) == '0 &&
                bridge_general_status[BDS_GEN_PWM_PIN] == $past(pwm_sync))
    else $error("restart did not clear status");

  chk_read_data: assert property (@(posedge clk) disable iff (rst)
    (acc.rd && hit_reg) |=> acc_rvalid && acc_rdata == $past(gate_delay_regulation_status))
    else $error("read data mismatch");

  chk_reset_zero: assert property (@(posedge clk)
    $fell(rst) |-> bridge_general_status == BDS_GEN_RESET && gate_delay_regulation_status == BDS_REG_RESET)
    else $error("status not zero after reset");

  // ----------------------------------------------------------------
  // qualification checks, both bridges
  // ----------------------------------------------------------------
  // each clamp bit is checked alone, so a swapped field cannot hide
  chk_level_gate_b1: assert property (@(posedge clk) disable iff (rst)
    (!charge_pump_on || bridge1_cfg.mode != BDS_MODE_ACTIVE) |=> !bridge_general_status[BDS_GEN_B1_LEVEL])
    else $error("bridge-1 level set while gated");

  chk_clamp_idle_b2: assert property (@(posedge clk) disable iff (rst)
    (!restart && (!bridge2_cfg.pwm_on || bridge2_cfg.high_z || !adaptive_gate_control[1]))
      |=> gate_delay_regulation_status[BDS_REG_B2_PRE] && gate_delay_regulation_status[BDS_REG_B2_PREDIS])
    else $error("bridge-2 clamp bits low while inactive");

  chk_clamp_free_b1: assert property (@(posedge clk) disable iff (rst)
    (!restart && !b1_sense_sync.pre_clamp && !b1_sense_sync.predis_clamp)
      |=> gate_delay_regulation_status[BDS_REG_B1_PRE] && gate_delay_regulation_status[BDS_REG_B1_PREDIS])
    else $error("bridge-1 clamp bits low without clamp");

  chk_clamp_free_b2: assert property (@(posedge clk) disable iff (rst)
    (!restart && !b2_sense_sync.pre_clamp && !b2_sense_sync.predis_clamp)
      |=> gate_delay_regulation_status[BDS_REG_B2_PRE] && gate_delay_regulation_status[BDS_REG_B2_PREDIS])
    else $error("bridge-2 clamp bits low without clamp");

  chk_predis_b1: assert property (@(posedge clk) disable iff (rst)
    (!restart && bridge1_cfg.pwm_on && !bridge1_cfg.high_z && adaptive_gate_control[1]
      && b1_sense_sync.predis_clamp)
      |=> !gate_delay_regulation_status[BDS_REG_B1_PREDIS])
    else $error("bridge-1 predischarge clamp not reported");

  chk_predis_b2: assert property (@(posedge clk) disable iff (rst)
    (!restart && bridge2_cfg.pwm_on && !bridge2_cfg.high_z && adaptive_gate_control[1]
      && b2_sense_sync.predis_clamp)
      |=> !gate_delay_regulation_status[BDS_REG_B2_PREDIS])
    else $error("bridge-2 predischarge clamp not reported");

  chk_pre_b1: assert property (@(posedge clk) disable iff (rst)
    (!restart && bridge1_cfg.pwm_on && !bridge1_cfg.high_z && adaptive_gate_control[1]
      && b1_sense_sync.pre_clamp)
      |=> !gate_delay_regulation_status[BDS_REG_B1_PRE])
    else $error("bridge-1 precharge clamp not reported");

  chk_pre_b2: assert property (@(posedge clk) disable iff (rst)
    (!restart && bridge2_cfg.pwm_on && !bridge2_cfg.high_z && adaptive_gate_control[1]
      && b2_sense_sync.pre_clamp)
      |=> !gate_delay_regulation_status[BDS_REG_B2_PRE])
    else $error("bridge-2 precharge clamp not reported");

  // ----------------------------------------------------------------
  // restart and pin checks
  // ----------------------------------------------------------------
  // restart must not blank the live bits, only the rest
  chk_restart_live: assert property (@(posedge clk) disable iff (rst)
    (restart && charge_pump_on && bridge1_cfg.mode == BDS_MODE_ACTIVE && bridge2_cfg.mode == BDS_MODE_ACTIVE
      && b1_sense_sync.out_high && b2_sense_sync.out_high)
      |=> bridge_general_status[BDS_GEN_B1_LEVEL] && bridge_general_status[BDS_GEN_B2_LEVEL])
    else $error("restart dropped a live level bit");

  chk_restart_gen: assert property (@(posedge clk) disable iff (rst)
    restart |=> (bridge_general_status & ~BDS_KEEP_MASK) == '0)
    else $error("restart left general bits set");

  chk_pwm_fall: assert property (@(posedge clk) disable iff (rst)
    $fell(pwm_sync) |=> !bridge_general_status[BDS_GEN_PWM_PIN])
    else $error("pwm pin low not mirrored");

  chk_pwm_follow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> bridge_general_status[BDS_GEN_PWM_PIN] == $past(pwm_sync))
    else $error("pwm pin level lags");

  // ----------------------------------------------------------------
  // access port checks
  // ----------------------------------------------------------------
  // every access is answered once; the host has no timeout of its own
  chk_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
    (acc.rd || acc.wr) |=> acc_rvalid)
    else $error("access not answered");

  chk_rvalid_idle: assert property (@(posedge clk) disable iff (rst)
    !(acc.rd || acc.wr) |=> !acc_rvalid && !acc_miss)
    else $error("answer without access");

  chk_miss_flag: assert property (@(posedge clk) disable iff (rst)
    ((acc.rd || acc.wr) && acc.addr != BDS_ADDR_GEN && acc.addr != BDS_ADDR_REG) |=> acc_miss)
    else $error("unmapped access not flagged");

  chk_hit_no_miss: assert property (@(posedge clk) disable iff (rst)
    ((acc.addr == BDS_ADDR_GEN) || (acc.addr == BDS_ADDR_REG)) |=> !acc_miss)
    else $error("mapped access flagged as miss");

  chk_write_drop: assert property (@(posedge clk) disable iff (rst)
    (acc.wr && !acc.rd) |=> acc_rdata == '0)
    else $error("write returned data");

  chk_read_gen: assert property (@(posedge clk) disable iff (rst)
    (acc.rd && acc.addr == BDS_ADDR_GEN) |=> acc_rvalid && acc_rdata == $past(bridge_general_status))
    else $error("general read data mismatch");

endmodule : bds_status_regs

// >>> sim/bds_host_model.sv
// host-side access model for the status register port
`timescale 1ns/1ps
module bds_host_model
  import bds_pkg::*;
(
  input  wire logic                          clk,
  output bds_pkg::bds_acc_s                  acc,
  input  wire logic [bds_pkg::BDS_DATA_W-1:0] acc_rdata,
  input  wire logic                          acc_rvalid,
  input  wire logic                          acc_miss
);
  import bds_pkg::*;
  // ------------------------------------------------------------
  // access strobe
  // ------------------------------------------------------------
  // idle lines carry the inverse of the last value, so a stale address never looks valid
  initial acc = '{rd: 1'b0, wr: 1'b0, addr: 7'h2a, wdata: 16'h5a5a};

  // one strobe cycle; the answer stands in the cycle after the taking edge
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output logic miss, output logic ok);
    @(negedge clk);
    acc = '{rd: ~wr, wr: wr, addr: a, wdata: wd};
    @(negedge clk);
    ok = acc_rvalid;
    rd = acc_rdata;
    miss = acc_miss;
    acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd};
  endtask : xfer
endmodule : bds_host_model

// >>> sim/test_bds_status_regs.sv
// self-checking bench for the bridge driver status registers
`timescale 1ns/1ps
module test_bds_status_regs;
  import bds_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              restart = 1'b0;
  logic              pin = 1'b0;
  logic              pump = 1'b0;
  logic [1:0]        gctl = 2'h0;
  bds_bridge_sense_s s1 = '0;
  bds_bridge_sense_s s2 = '0;
  bds_bridge_cfg_s   c1 = '0;
  bds_bridge_cfg_s   c2 = '0;
  bds_acc_s          acc;
  logic [15:0]       rdata;
  logic              rvalid;
  logic              miss;
  int                error_cnt = 0;
  int                check_count = 0;
  int                cycles = 0;

  always #5 clk = ~clk;

  bds_status_regs DUT (.clk(clk), .rst(rst), .restart(restart), .pwm_pin_level(pin), .bridge1_sense(s1),
    .bridge2_sense(s2), .bridge1_cfg(c1), .bridge2_cfg(c2), .charge_pump_on(pump),
    .adaptive_gate_control(gctl), .acc(acc), .acc_rdata(rdata), .acc_rvalid(rvalid), .acc_miss(miss));
  bds_host_model host (.clk(clk), .acc(acc), .acc_rdata(rdata), .acc_rvalid(rvalid), .acc_miss(miss));

  // ------------------------------------------------------------
  // verdict, comparison and expectations
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // a hang is cut short well above the longest expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic lvl(bds_bridge_sense_s s, bds_bridge_cfg_s c);
    return s.out_high & pump & (c.mode == 2'h3);
  endfunction : lvl

  // clamp bit drops only under active gate control with a driven, pwm bridge
  function automatic logic cl(logic clamp, bds_bridge_cfg_s c);
    return ~(clamp & c.pwm_on & ~c.high_z & gctl[1]);
  endfunction : cl

  function automatic logic [15:0] exp_gen();
    return {8'h00, lvl(s2, c2), lvl(s1, c1), 5'h00, pin};
  endfunction : exp_gen

  function automatic logic [15:0] exp_reg();
    return {6'h00, cl(s2.predis_clamp, c2), cl(s1.predis_clamp, c1), 2'h0, cl(s2.pre_clamp, c2),
            cl(s1.pre_clamp, c1), 2'h0, s2.delay_reg, s1.delay_reg};
  endfunction : exp_reg

  task automatic acc_chk(logic wr, logic [6:0] a, logic [15:0] e, logic em);
    logic [15:0] d;
    logic        m;
    logic        ok;
    host.xfer(wr, a, 16'hffff, d, m, ok);
    check("rvalid", {15'h0000, ok}, 16'h0001);
    check("miss", {15'h0000, m}, {15'h0000, em});
    check("rdata", d, e);
  endtask : acc_chk

  // wait out the synchroniser, then read both registers
  task automatic both();
    repeat (6) @(negedge clk);
    acc_chk(1'b0, 7'h50, exp_gen(), 1'b0);
    acc_chk(1'b0, 7'h51, exp_reg(), 1'b0);
  endtask : both

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_levels();
    s1.out_high = 1'b1;
    s2.out_high = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        @(negedge clk);
        pump = p[0];
        c1.mode = m[1:0];
        c2.mode = 2'h3 - m[1:0];
        pin = m[0];
        both();
      end
    end
  endtask : t_levels

  task automatic t_clamps();
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 16; k++) begin
        @(negedge clk);
        gctl = g[1:0];
        c1.pwm_on = k[0];
        c1.high_z = k[1];
        c2.pwm_on = k[1];
        c2.high_z = k[0] & k[3];
        s1 = '{out_high: 1'b0, pre_clamp: k[2], predis_clamp: k[3], delay_reg: k[0] ^ k[2]};
        s2 = '{out_high: 1'b0, pre_clamp: k[3], predis_clamp: k[2], delay_reg: k[1]};
        both();
      end
    end
  endtask : t_clamps

  // writes are dropped, reads clear nothing, other addresses miss
  task automatic t_access();
    acc_chk(1'b1, 7'h50, 16'h0000, 1'b0);
    acc_chk(1'b1, 7'h51, 16'h0000, 1'b0);
    both();
    both();
    acc_chk(1'b0, 7'h4f, 16'h0000, 1'b1);
    acc_chk(1'b0, 7'h52, 16'h0000, 1'b1);
  endtask : t_access

  // restart keeps bits 7, 6, 0 live for one cycle and clears the rest
  task automatic t_restart();
    logic [15:0] e;
    pin = 1'b1;
    pump = 1'b1;
    gctl = 2'h0;
    c1.mode = 2'h3;
    c2.mode = 2'h3;
    s1 = '{out_high: 1'b1, pre_clamp: 1'b0, predis_clamp: 1'b0, delay_reg: 1'b1};
    s2 = '{out_high: 1'b1, pre_clamp: 1'b0, predis_clamp: 1'b0, delay_reg: 1'b0};
    both();
    for (int r = 0; r < 2; r++) begin
      e = (r == 0) ? exp_gen() : exp_reg();
      @(negedge clk);
      restart = 1'b1;
      fork
        begin
          @(negedge clk);
          restart = 1'b0;
        end
        acc_chk(1'b0, 7'h50 + 7'(r), e & 16'h00c1, 1'b0);
      join
    end
    both();
  endtask : t_restart

  // a mid-run reset clears the level bits although the inputs stay high
  task automatic t_reset();
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    acc_chk(1'b0, 7'h50, 16'h0000, 1'b0);
    both();
  endtask : t_reset

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    acc_chk(1'b0, 7'h50, 16'h0000, 1'b0);
    t_levels();
    t_clamps();
    t_access();
    t_restart();
    t_reset();
    complete_run();
  end
endmodule : test_bds_status_regs
